// ==== include/dps_pkg.sv ====
// ----------------------------------------------------------------
// Shared constants of the dual-port burst SRAM pin logic
// ----------------------------------------------------------------
package dps_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int BURST_LEN = 4;        // Beats per access
  localparam int BEAT_W = 2;           // Bits that number a beat
  localparam int LANE_W = 9;           // Bits governed by one byte select
  localparam int RD_STAGES = 4;        // Depth of the read delay line
  localparam int SYNC_STAGES = 2;      // Flops in every synchroniser
  localparam int STAT_W = 3;           // Status bits sent to the system clock

  // ----------------------------------------------------------------
  // Beat positions inside the read delay line
  // ----------------------------------------------------------------
  localparam int PLL_FIRST_STAGE = 2;  // 2.5 cycle latency: beats 0/1 from stage 2
  localparam int PLL_LAST_STAGE = 3;   // Beats 2/3 from stage 3
  localparam int LEG_FIRST_STAGE = 0;  // One cycle latency: beat 0 from stage 0
  localparam int LEG_MID_STAGE = 1;    // Beats 1/2 from stage 1
  localparam int LEG_LAST_STAGE = 2;   // Beat 3 from stage 2

  // ----------------------------------------------------------------
  // Legacy mode clock limit, informative only
  // ----------------------------------------------------------------
  localparam int LEGACY_MAX_MHZ = 167;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [SYNC_STAGES-1:0] RST_SYNC_INIT = 2'h3;  // Link reset held
  localparam logic [SYNC_STAGES-1:0] PLL_SYNC_INIT = 2'h3;  // PLL assumed on
  localparam logic [STAT_W-1:0] STAT_INIT = 3'h0;

  // ----------------------------------------------------------------
  // Write sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DPS_WR_IDLE,
    DPS_WR_FIRST,
    DPS_WR_SECOND
  } dps_wr_state_t;

endpackage

// ==== logic/dps_sram_pins.sv ====
// Contract
// - Write data is captured on both clock phases only during a write.
// - Low write select at a positive edge starts a write.
// - Deselected write port ignores write data.
// - Byte selects sampled with the data beat they qualify, both phases.
// - Deselected byte is discarded; the stored byte stays unchanged.
// - Each byte select governs a nine-bit lane, lane n at bits 9n+8..9n.
// - One shared address bus, sampled at the positive edge, serves both ports.
// - Wide variant decodes 18 address bits, narrow 19; four beats each.
// - Address ignored for a port that is deselected on that edge.
// - Read data driven one beat per edge on both clock phases.
// - Deselected read port floats the read data outputs.
// - Low read select at a positive edge starts a read.
// - A pending read finishes, then outputs float after the next edge.
// - Each read returns four beats from sequential locations.
// - Read valid marks valid data, aligned to the echo clocks.
// - Every access begins on a positive input clock rising edge.
// - Echo clocks run freely, locked to the positive input clock.
// - PLL disable low selects one-cycle legacy read latency.
`timescale 1ns/100ps

module dps_sram_pins #(
  parameter int DATA_W = 18,                      // 18 or 36
  parameter int ADDR_W = 19,                      // 19 for 18 bits, 18 for 36 bits
  parameter int LANES = DATA_W / dps_pkg::LANE_W  // Byte select count
) (
  input wire logic clk_in,                        // System clock, 100 MHz
  input wire logic reset_in,                      // Asynchronous, active high
  input wire logic k_clk_in,                      // Positive input clock
  input wire logic pll_disable_n_in,              // Low selects legacy timing
  input wire logic [ADDR_W-1:0] addr_in,          // Shared address bus
  input wire logic write_port_select_n_in,        // Write select, active low
  input wire logic read_port_select_n_in,         // Read select, active low
  input wire logic [DATA_W-1:0] write_data_in,    // Write data, both phases
  input wire logic [LANES-1:0] byte_write_select_n_in, // Lane selects, active low
  output logic [DATA_W-1:0] read_data_out,        // Read data
  output logic read_data_oe_out,                  // High while read data is driven
  output logic read_valid_out,                    // Read data valid
  output logic echo_clock_out,                    // Echo clock
  output logic echo_clock_n_out,                  // Complementary echo clock
  output logic read_busy_out,                     // Read burst in flight, clk_in side
  output logic write_busy_out,                    // Write burst in flight, clk_in side
  output logic legacy_mode_out                    // Legacy timing active, clk_in side
);

  localparam int BL = dps_pkg::BURST_LEN;
  localparam int BW = dps_pkg::BEAT_W;
  localparam int LW = dps_pkg::LANE_W;
  localparam int RS = dps_pkg::RD_STAGES;
  localparam int SS = dps_pkg::SYNC_STAGES;
  localparam int DEPTH = BL << ADDR_W;

  // ----------------------------------------------------------------
  // Link reset and mode strap
  // ----------------------------------------------------------------
  logic [SS-1:0] rst_sync_ff;
  logic rst_k;
  logic [SS-1:0] pll_sync_ff;
  logic legacy_mode;

  // Reset is asserted at once and released on the link clock
  always_ff @(posedge k_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rst_sync_ff <= dps_pkg::RST_SYNC_INIT;
    end else begin
      rst_sync_ff <= {rst_sync_ff[SS-2:0], 1'b0};
    end
  end
  assign rst_k = rst_sync_ff[SS-1];

  // The strap is a board level; changing it mid-burst gives undefined beats
  always_ff @(posedge k_clk_in or posedge rst_k) begin
    if (rst_k) begin
      pll_sync_ff <= dps_pkg::PLL_SYNC_INIT;
    end else begin
      pll_sync_ff <= {pll_sync_ff[SS-2:0], pll_disable_n_in};
    end
  end
  assign legacy_mode = ~pll_sync_ff[SS-1];

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] mem [DEPTH];

  // ----------------------------------------------------------------
  // Write port
  // ----------------------------------------------------------------
  dps_pkg::dps_wr_state_t wr_state_ff;
  logic wr_accept;
  logic [ADDR_W-1:0] wr_addr_ff;
  logic [ADDR_W-1:0] cmt_addr_ff;
  logic cmt_ff;
  logic [DATA_W-1:0] wr_data_ff [BL-1];
  logic [LANES-1:0] wr_mask_ff [BL-1];
  logic [DATA_W-1:0] neg_data_ff;
  logic [LANES-1:0] neg_mask_ff;

  // A new write may start while the previous one takes its last beats
  assign wr_accept = ~write_port_select_n_in &
    ((wr_state_ff == dps_pkg::DPS_WR_IDLE) | (wr_state_ff == dps_pkg::DPS_WR_SECOND));

  // Write sequencer: command edge, then beats 0..3 on the four edges from the next rising edge
  always_ff @(posedge k_clk_in or posedge rst_k) begin
    if (rst_k) begin
      wr_state_ff <= dps_pkg::DPS_WR_IDLE;
    end else begin
      unique case (wr_state_ff)
        dps_pkg::DPS_WR_IDLE: begin
          if (wr_accept) begin
            wr_state_ff <= dps_pkg::DPS_WR_FIRST;
          end
        end
        dps_pkg::DPS_WR_FIRST: begin
          wr_state_ff <= dps_pkg::DPS_WR_SECOND;
        end
        dps_pkg::DPS_WR_SECOND: begin
          wr_state_ff <= wr_accept ? dps_pkg::DPS_WR_FIRST : dps_pkg::DPS_WR_IDLE;
        end
      endcase
    end
  end

  // Address is taken only with an accepted write; otherwise ignored
  always_ff @(posedge k_clk_in or posedge rst_k) begin
    if (rst_k) begin
      wr_addr_ff <= '0;
    end else if (wr_accept) begin
      wr_addr_ff <= addr_in;
    end
  end

  // Positive-phase beats 0 and 2; beat 1 moves over from the negative phase
  always_ff @(posedge k_clk_in or posedge rst_k) begin
    if (rst_k) begin
      for (int i = 0; i < BL - 1; i++) begin
        wr_data_ff[i] <= '0;
        wr_mask_ff[i] <= '1;
      end
      cmt_ff <= 1'b0;
      cmt_addr_ff <= '0;
    end else begin
      cmt_ff <= (wr_state_ff == dps_pkg::DPS_WR_SECOND);
      if (wr_state_ff == dps_pkg::DPS_WR_FIRST) begin
        wr_data_ff[0] <= write_data_in;
        wr_mask_ff[0] <= byte_write_select_n_in;
      end
      if (wr_state_ff == dps_pkg::DPS_WR_SECOND) begin
        wr_data_ff[1] <= neg_data_ff;
        wr_mask_ff[1] <= neg_mask_ff;
        wr_data_ff[2] <= write_data_in;
        wr_mask_ff[2] <= byte_write_select_n_in;
        cmt_addr_ff <= wr_addr_ff;
      end
    end
  end

  // Negative-phase beats 1 and 3, taken only inside a write burst
  always_ff @(negedge k_clk_in or posedge rst_k) begin
    if (rst_k) begin
      neg_data_ff <= '0;
      neg_mask_ff <= '1;
    end else if ((wr_state_ff == dps_pkg::DPS_WR_SECOND) | cmt_ff) begin
      neg_data_ff <= write_data_in;
      neg_mask_ff <= byte_write_select_n_in;
    end
  end

  // Whole burst is committed at once; a held-high lane select leaves memory alone
  always_ff @(posedge k_clk_in) begin
    if (cmt_ff) begin
      for (int b = 0; b < BL; b++) begin
        for (int l = 0; l < LANES; l++) begin
          if (!((b == BL - 1) ? neg_mask_ff[l] : wr_mask_ff[b][l])) begin
            mem[{cmt_addr_ff, BW'(b)}][l*LW +: LW] <=
              (b == BL - 1) ? neg_data_ff[l*LW +: LW] : wr_data_ff[b][l*LW +: LW];
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  logic rd_accept;
  logic rd_v_ff [RS];
  logic [DATA_W-1:0] rd_d_ff [RS][BL];
  logic [DATA_W-1:0] q_pos_ff;
  logic [DATA_W-1:0] q_neg_ff;
  logic vld_pos_ff;
  logic vld_neg_ff;

  // Reads start every other edge at most, one burst per two cycles
  assign rd_accept = ~read_port_select_n_in & ~rd_v_ff[0];

  // Delay line: stage 0 fetches four sequential words, later stages shift
  always_ff @(posedge k_clk_in or posedge rst_k) begin
    if (rst_k) begin
      for (int s = 0; s < RS; s++) begin
        rd_v_ff[s] <= 1'b0;
        for (int b = 0; b < BL; b++) begin
          rd_d_ff[s][b] <= '0;
        end
      end
    end else begin
      rd_v_ff[0] <= rd_accept;
      if (rd_accept) begin
        for (int b = 0; b < BL; b++) begin
          rd_d_ff[0][b] <= mem[{addr_in, BW'(b)}];
        end
      end
      for (int s = 1; s < RS; s++) begin
        rd_v_ff[s] <= rd_v_ff[s-1];
        rd_d_ff[s] <= rd_d_ff[s-1];
      end
    end
  end

  // Positive phase beats: beats 1 and 3 with the PLL, beats 0 and 2 in legacy mode
  always_ff @(posedge k_clk_in or posedge rst_k) begin
    if (rst_k) begin
      q_pos_ff <= '0;
      vld_pos_ff <= 1'b0;
    end else if (legacy_mode && rd_v_ff[dps_pkg::LEG_FIRST_STAGE]) begin
      q_pos_ff <= rd_d_ff[dps_pkg::LEG_FIRST_STAGE][0];
      vld_pos_ff <= 1'b1;
    end else if (legacy_mode && rd_v_ff[dps_pkg::LEG_MID_STAGE]) begin
      q_pos_ff <= rd_d_ff[dps_pkg::LEG_MID_STAGE][2];
      vld_pos_ff <= 1'b1;
    end else if (!legacy_mode && rd_v_ff[dps_pkg::PLL_FIRST_STAGE]) begin
      q_pos_ff <= rd_d_ff[dps_pkg::PLL_FIRST_STAGE][1];
      vld_pos_ff <= 1'b1;
    end else if (!legacy_mode && rd_v_ff[dps_pkg::PLL_LAST_STAGE]) begin
      q_pos_ff <= rd_d_ff[dps_pkg::PLL_LAST_STAGE][3];
      vld_pos_ff <= 1'b1;
    end else begin
      q_pos_ff <= '0;
      vld_pos_ff <= 1'b0;
    end
  end

  // Negative phase beats, from the same delay line
  always_ff @(negedge k_clk_in or posedge rst_k) begin
    if (rst_k) begin
      q_neg_ff <= '0;
      vld_neg_ff <= 1'b0;
    end else if (legacy_mode && rd_v_ff[dps_pkg::LEG_MID_STAGE]) begin
      q_neg_ff <= rd_d_ff[dps_pkg::LEG_MID_STAGE][1];
      vld_neg_ff <= 1'b1;
    end else if (legacy_mode && rd_v_ff[dps_pkg::LEG_LAST_STAGE]) begin
      q_neg_ff <= rd_d_ff[dps_pkg::LEG_LAST_STAGE][3];
      vld_neg_ff <= 1'b1;
    end else if (!legacy_mode && rd_v_ff[dps_pkg::PLL_FIRST_STAGE]) begin
      q_neg_ff <= rd_d_ff[dps_pkg::PLL_FIRST_STAGE][0];
      vld_neg_ff <= 1'b1;
    end else if (!legacy_mode && rd_v_ff[dps_pkg::PLL_LAST_STAGE]) begin
      q_neg_ff <= rd_d_ff[dps_pkg::PLL_LAST_STAGE][2];
      vld_neg_ff <= 1'b1;
    end else begin
      q_neg_ff <= '0;
      vld_neg_ff <= 1'b0;
    end
  end

  // Clock level picks the phase register; drivers float with no valid beat
  assign read_data_out = k_clk_in ? q_pos_ff : q_neg_ff;
  assign read_valid_out = k_clk_in ? vld_pos_ff : vld_neg_ff;
  assign read_data_oe_out = read_valid_out;

  // Echo clocks are the input clock forwarded, so valid switches with them
  assign echo_clock_out = k_clk_in;
  assign echo_clock_n_out = ~k_clk_in;

  // ----------------------------------------------------------------
  // Status toward the system clock
  // ----------------------------------------------------------------
  logic [dps_pkg::STAT_W-1:0] stat_k_ff;
  logic [dps_pkg::STAT_W-1:0] stat_s1_ff;
  logic [dps_pkg::STAT_W-1:0] stat_s2_ff;

  // Registered first so the crossing never sees gate glitches
  always_ff @(posedge k_clk_in or posedge rst_k) begin
    if (rst_k) begin
      stat_k_ff <= dps_pkg::STAT_INIT;
    end else begin
      stat_k_ff <= {legacy_mode, wr_state_ff != dps_pkg::DPS_WR_IDLE,
                    rd_v_ff[0] | rd_v_ff[1] | rd_v_ff[2] | rd_v_ff[3]};
    end
  end

  // Two-flop level synchroniser; the bits are independent levels
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      stat_s1_ff <= dps_pkg::STAT_INIT;
      stat_s2_ff <= dps_pkg::STAT_INIT;
    end else begin
      stat_s1_ff <= stat_k_ff;
      stat_s2_ff <= stat_s1_ff;
    end
  end
  assign read_busy_out = stat_s2_ff[0];
  assign write_busy_out = stat_s2_ff[1];
  assign legacy_mode_out = stat_s2_ff[2];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge k_clk_in); endclocking
  default disable iff (rst_k);

  a_wr_start_seq: assert property (wr_accept |=> wr_state_ff == dps_pkg::DPS_WR_FIRST ##1
    wr_state_ff == dps_pkg::DPS_WR_SECOND ##1 cmt_ff)
    else $error("write burst did not sequence after accept");
  a_wr_desel_idle: assert property ((wr_state_ff == dps_pkg::DPS_WR_IDLE &&
    write_port_select_n_in) |=> wr_state_ff == dps_pkg::DPS_WR_IDLE && $stable(wr_addr_ff))
    else $error("deselected write port changed state");
  a_wr_commit_addr: assert property (wr_accept |-> ##3 cmt_ff && cmt_addr_ff == $past(addr_in, 3))
    else $error("write commit address or timing wrong");
  a_rd_pll_latency: assert property ((rd_accept && !legacy_mode) ##1 (!legacy_mode)[*2]
    |=> vld_neg_ff ##1 (vld_pos_ff && vld_neg_ff))
    else $error("read beat not present 2.5 cycles after command");
  a_rd_legacy_lat: assert property ((rd_accept && legacy_mode) ##1 legacy_mode
    |=> vld_pos_ff && q_pos_ff == rd_d_ff[1][0])
    else $error("legacy read beat zero late or wrong");
  a_rd_desel_none: assert property (read_port_select_n_in |=> !rd_v_ff[0])
    else $error("deselected read port started a read");
  a_rd_burst_end: assert property ((rd_accept && !legacy_mode) ##1 (!rd_accept && !legacy_mode)[*4]
    |=> ##1 !vld_pos_ff && !vld_neg_ff)
    else $error("read outputs still valid after the burst");
  a_rd_beat_data: assert property ((vld_pos_ff && !legacy_mode && rd_v_ff[3]) |->
    q_pos_ff == rd_d_ff[3][1])
    else $error("read beat one does not match fetched word");

  c_pll_read: cover property (rd_accept && !legacy_mode ##4 vld_pos_ff);
  c_legacy_read: cover property (rd_accept && legacy_mode ##2 vld_pos_ff);
  c_masked_write: cover property (cmt_ff && neg_mask_ff != '0 && neg_mask_ff != '1);
  c_back_to_back: cover property (wr_accept ##2 wr_accept);

endmodule

// ==== dv/dps_ctrl_model.sv ====
`timescale 1ns/100ps

// ----------------------------------------------------------------
// Memory controller on the far side of the pins
// ----------------------------------------------------------------
module dps_ctrl_model #(
  parameter int DATA_W = 18,
  parameter int ADDR_W = 19,
  parameter int LANES = 2
) (
  input wire logic k_clk_in,                    // Link clock
  input wire logic [DATA_W-1:0] read_data_in,   // Read beats
  input wire logic read_data_oe_in,             // Read drivers on
  input wire logic read_valid_in,               // Read beat valid
  input wire logic echo_clock_in,               // Echo clock
  input wire logic echo_clock_n_in,             // Echo clock inverse
  output logic [ADDR_W-1:0] addr_out,           // Shared address
  output logic write_port_select_n_out,         // Write select
  output logic read_port_select_n_out,          // Read select
  output logic [DATA_W-1:0] write_data_out,     // Write beats
  output logic [LANES-1:0] byte_write_select_n_out // Lane selects
);
  int krise;

  // Idle levels; data lines carry no pull, so they toggle later
  initial begin
    krise = 0;
    addr_out = '0;
    write_port_select_n_out = 1'b1;
    read_port_select_n_out = 1'b1;
    write_data_out = '0;
    byte_write_select_n_out = '1;
  end

  // Rising edges counted to place read sampling points
  always @(posedge k_clk_in) begin
    krise++;
  end

  // Inputs change a quarter cycle after an edge, away from sampling
  task automatic wr_burst(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d [4],
      input logic [LANES-1:0] b [4], input logic sel_n, input bit last);
    @(posedge k_clk_in);
    #7.5;
    write_port_select_n_out = sel_n;
    addr_out = a;
    @(posedge k_clk_in);
    #7.5;
    write_port_select_n_out = 1'b1;
    addr_out = ~a;
    @(negedge k_clk_in);
    #7.5;
    for (int i = 0; i < 4; i++) begin
      write_data_out = d[i];
      byte_write_select_n_out = b[i];
      @(k_clk_in);
      #7.5;
    end
    // Skipped when a following burst owns the data lines
    if (last) begin
      write_data_out = ~d[3];
      byte_write_select_n_out = ~b[3];
    end
  endtask

  // One read; hold keeps select low over the next rise
  task automatic rd_burst(input logic [ADDR_W-1:0] a, input bit legacy, input bit hold,
      input bit last, output logic [DATA_W-1:0] q [4], output logic [3:0] v, output bit ok);
    int c0;
    int lat;
    ok = 1'b1;
    lat = legacy ? 1 : 2;
    @(posedge k_clk_in);
    #7.5;
    read_port_select_n_out = 1'b0;
    addr_out = a;
    @(posedge k_clk_in);
    #7.5;
    // Read away from the edge so the edge counter has surely moved on
    c0 = krise;
    addr_out = ~a;
    if (hold) begin
      @(posedge k_clk_in);
      #7.5;
    end
    read_port_select_n_out = 1'b1;
    wait (krise == c0 + lat);
    if (!legacy) begin
      @(negedge k_clk_in);
    end
    #7.5;
    for (int i = 0; i < 5; i++) begin
      if (echo_clock_in !== k_clk_in || echo_clock_n_in !== ~k_clk_in) begin
        ok = 1'b0;
      end
      if (read_data_oe_in !== read_valid_in) begin
        ok = 1'b0;
      end
      if (i < 4) begin
        q[i] = read_data_in;
        v[i] = read_valid_in;
        @(k_clk_in);
        #7.5;
      end else if (last && read_valid_in !== 1'b0) begin
        ok = 1'b0;
      end
    end
  endtask
endmodule

// ==== dv/dps_sram_pins_tb.sv ====
`timescale 1ns/100ps

module dps_sram_pins_tb;
  logic clk_in;
  logic reset_in;
  logic k_clk_in;
  logic pll_disable_n_in;
  logic [18:0] addr;
  logic wps_n;
  logic rps_n;
  logic [17:0] wdata;
  logic [1:0] bws_n;
  logic [17:0] rdata;
  logic oe;
  logic valid;
  logic echo;
  logic echo_n;
  logic rbusy;
  logic wbusy;
  logic legacy;
  int err_count;
  int num_checks;
  bit wr_seen;
  bit rd_seen;
  logic [17:0] ref_mem [logic [20:0]];

  // ----------------------------------------------------------------
  // Clocks and instances
  // ----------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // Link clock offset so its edges never meet the system clock
  initial begin
    k_clk_in = 1'b0;
    #3.7;
    forever #15 k_clk_in = ~k_clk_in;
  end

  dps_sram_pins dut (.clk_in(clk_in), .reset_in(reset_in), .k_clk_in(k_clk_in),
    .pll_disable_n_in(pll_disable_n_in), .addr_in(addr), .write_port_select_n_in(wps_n),
    .read_port_select_n_in(rps_n), .write_data_in(wdata), .byte_write_select_n_in(bws_n),
    .read_data_out(rdata), .read_data_oe_out(oe), .read_valid_out(valid),
    .echo_clock_out(echo), .echo_clock_n_out(echo_n), .read_busy_out(rbusy),
    .write_busy_out(wbusy), .legacy_mode_out(legacy));

  dps_ctrl_model ctrl (.k_clk_in(k_clk_in), .read_data_in(rdata), .read_data_oe_in(oe),
    .read_valid_in(valid), .echo_clock_in(echo), .echo_clock_n_in(echo_n),
    .addr_out(addr), .write_port_select_n_out(wps_n), .read_port_select_n_out(rps_n),
    .write_data_out(wdata), .byte_write_select_n_out(bws_n));

  // Busy levels are short, so they are latched for later checks
  always @(posedge clk_in) begin
    if (wbusy === 1'b1) wr_seen = 1'b1;
    if (rbusy === 1'b1) rd_seen = 1'b1;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("Checks %0d, errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Reference image keeps lanes whose select was high
  task automatic do_write(input logic [18:0] a, input logic [17:0] d [4],
      input logic [1:0] b [4], input logic sel_n, input bit last);
    ctrl.wr_burst(a, d, b, sel_n, last);
    for (int i = 0; i < 4 && sel_n == 1'b0; i++) begin
      for (int n = 0; n < 2; n++) begin
        if (!b[i][n]) ref_mem[{a, i[1:0]}][n*9 +: 9] = d[i][n*9 +: 9];
      end
    end
  endtask

  task automatic do_read(input logic [18:0] a, input bit lg, input bit hold, input bit last);
    logic [17:0] q [4];
    logic [3:0] v;
    bit ok;
    ctrl.rd_burst(a, lg, hold, last, q, v, ok);
    for (int i = 0; i < 4; i++) begin
      check(q[i], ref_mem[{a, i[1:0]}], "read beat");
    end
    check(v, 4'hF, "valid beats");
    check(ok, 1'b1, "pin timing");
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic sc_write_read;
    logic [17:0] d [4];
    logic [1:0] b [4];
    d = '{18'h12345, 18'h2ABCD, 18'h00FF0, 18'h3F00F};
    b = '{2'h0, 2'h0, 2'h0, 2'h0};
    wr_seen = 1'b0;
    rd_seen = 1'b0;
    do_write(19'h00010, d, b, 1'b0, 1'b1);
    do_read(19'h00010, 1'b0, 1'b0, 1'b1);
    check(wr_seen, 1'b1, "write busy");
    check(rd_seen, 1'b1, "read busy");
    d = '{18'h3FFFF, 18'h00001, 18'h20000, 18'h15555};
    do_write(19'h7FFFF, d, b, 1'b0, 1'b1);
    do_read(19'h7FFFF, 1'b0, 1'b0, 1'b1);
  endtask

  // Lane masks change per beat: lane 0 only, lane 1 only, none, both
  task automatic sc_byte_lanes;
    logic [17:0] d [4];
    logic [1:0] b [4];
    d = '{18'h0AAAA, 18'h35555, 18'h3FFFF, 18'h0C3C3};
    b = '{2'h2, 2'h1, 2'h3, 2'h0};
    do_write(19'h00010, d, b, 1'b0, 1'b1);
    do_read(19'h00010, 1'b0, 1'b0, 1'b1);
  endtask

  // Data with open lanes while the write port is deselected
  task automatic sc_deselect;
    logic [17:0] d [4];
    logic [1:0] b [4];
    d = '{18'h11111, 18'h22222, 18'h33333, 18'h04444};
    b = '{2'h0, 2'h0, 2'h0, 2'h0};
    do_write(19'h00010, d, b, 1'b1, 1'b1);
    do_read(19'h00010, 1'b0, 1'b1, 1'b1);
  endtask

  // Writes and reads at the tightest spacing of two cycles
  task automatic sc_back_to_back;
    logic [17:0] d [4];
    logic [17:0] e [4];
    logic [1:0] b [4];
    d = '{18'h01234, 18'h05678, 18'h09ABC, 18'h0DEF0};
    e = '{18'h3CAFE, 18'h2BEEF, 18'h1F00D, 18'h0D00D};
    b = '{2'h0, 2'h0, 2'h0, 2'h0};
    fork
      do_write(19'h00020, d, b, 1'b0, 1'b0);
      begin
        repeat (2) @(posedge k_clk_in);
        do_write(19'h00021, e, b, 1'b0, 1'b1);
      end
    join
    fork
      do_read(19'h00020, 1'b0, 1'b0, 1'b0);
      begin
        repeat (2) @(posedge k_clk_in);
        do_read(19'h00021, 1'b0, 1'b0, 1'b1);
      end
    join
  endtask

  task automatic sc_legacy;
    @(negedge clk_in);
    pll_disable_n_in = 1'b0;
    repeat (10) @(posedge k_clk_in);
    @(negedge clk_in);
    check(legacy, 1'b1, "legacy status");
    do_read(19'h00021, 1'b1, 1'b0, 1'b1);
    @(negedge clk_in);
    pll_disable_n_in = 1'b1;
    repeat (10) @(posedge k_clk_in);
    @(negedge clk_in);
    check(legacy, 1'b0, "legacy status");
    do_read(19'h00020, 1'b0, 1'b0, 1'b1);
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    err_count = 0;
    num_checks = 0;
    reset_in = 1'b1;
    pll_disable_n_in = 1'b1;
    repeat (20) @(negedge clk_in);
    reset_in = 1'b0;
    check(oe, 1'b0, "drivers after reset");
    repeat (6) @(posedge k_clk_in);
    sc_write_read();
    sc_byte_lanes();
    sc_deselect();
    sc_back_to_back();
    sc_legacy();
    end_sim();
  end

  // The whole run needs about 3 us of link traffic
  initial begin
    #30000;
    err_count++;
    $display("Error at %0t: watchdog expired", $time);
    end_sim();
  end
endmodule
